// [rtl/qcs_pkg.sv]
// Shared constants and types for the questionable and calibration status groups
package qcs_pkg;

  // ----------------------------------------------------------------
  // Widths and bit positions
  // ----------------------------------------------------------------
  localparam int unsigned QCS_STATUS_W = 16;
  localparam int unsigned QCS_RESERVED_BIT = 15;
  localparam int unsigned QCS_CAL_SUMMARY_BIT = 8;
  localparam int unsigned QCS_CAL_FAIL_W = 5;

  // ----------------------------------------------------------------
  // Calibration failure bit positions
  // ----------------------------------------------------------------
  localparam int unsigned QCS_CAL_SPECTRUM_BIT = 0;
  localparam int unsigned QCS_CAL_SAMPLER_BIT = 1;
  localparam int unsigned QCS_CAL_COUNTER_BIT = 2;
  localparam int unsigned QCS_CAL_VOLTMETER_BIT = 3;
  localparam int unsigned QCS_CAL_TXZERO_BIT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] QCS_RISE_RESET = 16'h7fff;
  localparam logic [15:0] QCS_FALL_RESET = 16'h0000;
  localparam logic [15:0] QCS_EVENT_RESET = 16'h0000;
  localparam logic [15:0] QCS_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] QCS_COND_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Command selectors
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    QCS_GRP_QUESTIONABLE_GROUP = 1'b0,
    QCS_GRP_CAL = 1'b1
  } qcs_group_t;

  typedef enum logic [2:0] {
    QCS_REG_COND = 3'b000,
    QCS_REG_RISE = 3'b001,
    QCS_REG_FALL = 3'b010,
    QCS_REG_EVENT = 3'b011,
    QCS_REG_ENABLE = 3'b100
  } qcs_reg_t;

endpackage

// [rtl/qcs_status_group.sv]
// One status group: transition filters, latched events, enable mask, summary
`timescale 1ns/1ps
`default_nettype none
module qcs_status_group #(
  parameter int unsigned WIDTH = qcs_pkg::QCS_STATUS_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Live condition
  input wire logic [WIDTH-1:0] cond_i,
  // Register access
  input wire logic rise_wr_i,
  input wire logic fall_wr_i,
  input wire logic enable_wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic event_rd_i,
  input wire logic clear_status_i,
  // Register contents
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o,
  output logic [WIDTH-1:0] event_o,
  output logic [WIDTH-1:0] enable_o,
  output logic summary_o
);
  import qcs_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH != QCS_STATUS_W) begin : g_bad_width
    $error("qcs_status_group: WIDTH must be 16");
  end

  typedef struct packed {
    logic [WIDTH-1:0] cond_prev;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
    logic [WIDTH-1:0] evt;
    logic [WIDTH-1:0] enable;
  } qcs_grp_state_t;

  qcs_grp_state_t st_q;
  qcs_grp_state_t st_d;
  logic [WIDTH-1:0] set_bits;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.cond_prev = cond_i;
    set_bits = (cond_i & ~st_q.cond_prev & st_q.rise) |
               (~cond_i & st_q.cond_prev & st_q.fall);
    if (rise_wr_i) begin
      st_d.rise = wdata_i;
    end
    if (fall_wr_i) begin
      st_d.fall = wdata_i;
    end
    if (enable_wr_i) begin
      st_d.enable = wdata_i;
    end
    // Set wins over a clear in the same cycle
    st_d.evt = ((event_rd_i || clear_status_i) ? '0 : st_q.evt) | set_bits;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '{QCS_COND_RESET, QCS_RISE_RESET, QCS_FALL_RESET,
                QCS_EVENT_RESET, QCS_ENABLE_RESET};
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_o = st_q.rise;
  assign fall_o = st_q.fall;
  assign event_o = st_q.evt;
  assign enable_o = st_q.enable;
  assign summary_o = |(st_q.evt & st_q.enable);

endmodule
`default_nettype wire

// [rtl/qcs_status_top.sv]
// Questionable and calibration status register groups behind the status command port
// Overview of operation
// - All registers of both groups are sixteen bits wide.
// - Each group has condition, two filters, event, enable and a summary.
// - Condition bit 15 always reads zero.
// - Questionable condition bit 8 is the calibration summary; others read zero.
// - Calibration condition bits 0-4 are five failure flags; bits 5-14 zero.
// - Event register clears on its query and on clear-status.
// - Enable register changes only by a write; reading leaves it alone.
// - Condition query returns live condition and changes nothing.
// - Rising or falling filter query returns that filter.
// - A filter write stores the written value as the new mask.
// - Event query returns the latched event register.
// - Enable register may be read, and a write stores the new mask.
`timescale 1ns/1ps
`default_nettype none
module qcs_status_top #(
  parameter int unsigned CAL_FAIL_W = qcs_pkg::QCS_CAL_FAIL_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Status command port
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire qcs_pkg::qcs_group_t cmd_group_i,
  input wire qcs_pkg::qcs_reg_t cmd_reg_i,
  input wire logic [qcs_pkg::QCS_STATUS_W-1:0] cmd_data_i,
  input wire logic clear_status_i,
  // Calibration failure flags
  input wire logic [CAL_FAIL_W-1:0] cal_fail_i,
  // Query answer
  output logic rsp_valid_o,
  output logic [qcs_pkg::QCS_STATUS_W-1:0] rsp_data_o,
  // Summaries
  output logic questionable_group_summary_o,
  output logic cal_summary_o
);
  import qcs_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (CAL_FAIL_W != QCS_CAL_FAIL_W) begin : g_bad_fail_w
    $error("qcs_status_top: CAL_FAIL_W must be 5");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic cmd_hit(input logic valid, input logic wr, input logic want_wr,
                                   input qcs_group_t grp, input qcs_group_t want_grp,
                                   input qcs_reg_t sel, input qcs_reg_t want_sel);
    cmd_hit = valid && (wr == want_wr) && (grp == want_grp) && (sel == want_sel);
  endfunction

  function automatic logic [QCS_STATUS_W-1:0] reg_pick(input qcs_reg_t sel,
      input logic [QCS_STATUS_W-1:0] cond, input logic [QCS_STATUS_W-1:0] rise,
      input logic [QCS_STATUS_W-1:0] fall, input logic [QCS_STATUS_W-1:0] evt,
      input logic [QCS_STATUS_W-1:0] en);
    unique case (sel)
      QCS_REG_COND: reg_pick = cond;
      QCS_REG_RISE: reg_pick = rise;
      QCS_REG_FALL: reg_pick = fall;
      QCS_REG_EVENT: reg_pick = evt;
      QCS_REG_ENABLE: reg_pick = en;
      default: reg_pick = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Group wiring
  // ----------------------------------------------------------------
  logic [QCS_STATUS_W-1:0] questionable_condition;
  logic [QCS_STATUS_W-1:0] calibration_condition;
  logic [QCS_STATUS_W-1:0] questionable_group_rise;
  logic [QCS_STATUS_W-1:0] questionable_group_fall;
  logic [QCS_STATUS_W-1:0] questionable_group_event;
  logic [QCS_STATUS_W-1:0] questionable_group_enable;
  logic [QCS_STATUS_W-1:0] cal_rise;
  logic [QCS_STATUS_W-1:0] cal_fall;
  logic [QCS_STATUS_W-1:0] cal_event;
  logic [QCS_STATUS_W-1:0] cal_enable;
  logic questionable_group_sum;
  logic cal_sum;

  always_comb begin
    questionable_condition = '0;
    questionable_condition[QCS_CAL_SUMMARY_BIT] = cal_sum;
    questionable_condition[QCS_RESERVED_BIT] = 1'b0;
    calibration_condition = '0;
    calibration_condition[CAL_FAIL_W-1:0] = cal_fail_i;
    calibration_condition[QCS_RESERVED_BIT] = 1'b0;
  end

  qcs_status_group #(
    .WIDTH(QCS_STATUS_W)
  ) u_questionable_group_group (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .cond_i(questionable_condition),
    .rise_wr_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_QUESTIONABLE_GROUP,
                       cmd_reg_i, QCS_REG_RISE)),
    .fall_wr_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_QUESTIONABLE_GROUP,
                       cmd_reg_i, QCS_REG_FALL)),
    .enable_wr_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_QUESTIONABLE_GROUP,
                         cmd_reg_i, QCS_REG_ENABLE)),
    .wdata_i(cmd_data_i),
    .event_rd_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b0, cmd_group_i, QCS_GRP_QUESTIONABLE_GROUP,
                        cmd_reg_i, QCS_REG_EVENT)),
    .clear_status_i(clear_status_i),
    .rise_o(questionable_group_rise),
    .fall_o(questionable_group_fall),
    .event_o(questionable_group_event),
    .enable_o(questionable_group_enable),
    .summary_o(questionable_group_sum)
  );

  qcs_status_group #(
    .WIDTH(QCS_STATUS_W)
  ) u_cal_group (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .cond_i(calibration_condition),
    .rise_wr_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_CAL,
                       cmd_reg_i, QCS_REG_RISE)),
    .fall_wr_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_CAL,
                       cmd_reg_i, QCS_REG_FALL)),
    .enable_wr_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_CAL,
                         cmd_reg_i, QCS_REG_ENABLE)),
    .wdata_i(cmd_data_i),
    .event_rd_i(cmd_hit(cmd_valid_i, cmd_write_i, 1'b0, cmd_group_i, QCS_GRP_CAL,
                        cmd_reg_i, QCS_REG_EVENT)),
    .clear_status_i(clear_status_i),
    .rise_o(cal_rise),
    .fall_o(cal_fall),
    .event_o(cal_event),
    .enable_o(cal_enable),
    .summary_o(cal_sum)
  );

  // ----------------------------------------------------------------
  // Query answer register
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsp_valid;
    logic [QCS_STATUS_W-1:0] rsp_data;
  } qcs_top_state_t;

  qcs_top_state_t st_q;
  qcs_top_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.rsp_valid = cmd_valid_i && !cmd_write_i;
    if (cmd_valid_i && !cmd_write_i) begin
      if (cmd_group_i == QCS_GRP_QUESTIONABLE_GROUP) begin
        st_d.rsp_data = reg_pick(cmd_reg_i, questionable_condition, questionable_group_rise, questionable_group_fall,
                                 questionable_group_event, questionable_group_enable);
      end else begin
        st_d.rsp_data = reg_pick(cmd_reg_i, calibration_condition, cal_rise, cal_fall,
                                 cal_event, cal_enable);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '{1'b0, 16'h0000};
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp_valid_o = st_q.rsp_valid;
  assign rsp_data_o = st_q.rsp_data;
  assign questionable_group_summary_o = questionable_group_sum;
  assign cal_summary_o = cal_sum;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic rd_cond;
  logic rd_cal_event;
  logic wr_cal_enable;
  logic wr_questionable_group_rise;
  assign rd_cond = cmd_valid_i && !cmd_write_i && (cmd_reg_i == QCS_REG_COND);
  assign rd_cal_event = cmd_hit(cmd_valid_i, cmd_write_i, 1'b0, cmd_group_i, QCS_GRP_CAL,
                                cmd_reg_i, QCS_REG_EVENT);
  assign wr_cal_enable = cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_CAL,
                                 cmd_reg_i, QCS_REG_ENABLE);
  assign wr_questionable_group_rise = cmd_hit(cmd_valid_i, cmd_write_i, 1'b1, cmd_group_i, QCS_GRP_QUESTIONABLE_GROUP,
                                cmd_reg_i, QCS_REG_RISE);

  a_cond_query: assert property (
    rd_cond |=> rsp_valid_o && !rsp_data_o[QCS_RESERVED_BIT] &&
      rsp_data_o == ($past(cmd_group_i) == QCS_GRP_QUESTIONABLE_GROUP ? $past(questionable_condition) : $past(calibration_condition)))
    else $error("condition query answer wrong");

  a_cond_no_side: assert property (
    rd_cond && !clear_status_i |=> $stable(cal_enable) && $stable(questionable_group_rise))
    else $error("condition query changed a register");

  a_questionable_group_link: assert property (
    questionable_condition == (QCS_STATUS_W'(cal_summary_o) << QCS_CAL_SUMMARY_BIT))
    else $error("questionable condition not the calibration summary");

  a_calibration_condition_map: assert property (
    calibration_condition[CAL_FAIL_W-1:0] == cal_fail_i && calibration_condition[QCS_STATUS_W-1:CAL_FAIL_W] == '0)
    else $error("calibration condition bits wrong");

  a_event_query_clr: assert property (
    rd_cal_event && !$past(sys_rst_i) && $stable(calibration_condition) |=>
      cal_event == '0 && rsp_valid_o && rsp_data_o == $past(cal_event))
    else $error("event query did not clear or answer");

  a_status_clear: assert property (
    clear_status_i && !$past(sys_rst_i) && $stable(calibration_condition) && $stable(questionable_condition) |=>
      cal_event == '0 && questionable_group_event == '0)
    else $error("clear-status left an event set");

  a_enable_hold: assert property (
    !wr_cal_enable |=> $stable(cal_enable))
    else $error("enable changed without a write");

  a_enable_store: assert property (
    wr_cal_enable ##1 cmd_hit(cmd_valid_i, cmd_write_i, 1'b0, cmd_group_i, QCS_GRP_CAL,
                              cmd_reg_i, QCS_REG_ENABLE) |=>
      rsp_valid_o && rsp_data_o == $past(cmd_data_i, 2))
    else $error("enable write not stored");

  a_filter_store: assert property (
    wr_questionable_group_rise |=> questionable_group_rise == $past(cmd_data_i))
    else $error("rising filter write not stored");

  a_event_sets: assert property (
    !$past(sys_rst_i) && $rose(calibration_condition[QCS_CAL_SPECTRUM_BIT]) &&
      cal_rise[QCS_CAL_SPECTRUM_BIT] |=> cal_event[QCS_CAL_SPECTRUM_BIT])
    else $error("filtered rise did not latch an event");

  a_event_fall: assert property (
    !$past(sys_rst_i) && $fell(calibration_condition[QCS_CAL_TXZERO_BIT]) &&
      cal_fall[QCS_CAL_TXZERO_BIT] |=> cal_event[QCS_CAL_TXZERO_BIT])
    else $error("filtered fall did not latch an event");

  a_summary_or: assert property (
    (cal_event & cal_enable) != '0 && !rd_cal_event && !clear_status_i && !wr_cal_enable
      |=> cal_summary_o ##0 questionable_condition[QCS_CAL_SUMMARY_BIT])
    else $error("summary dropped while enabled event held");

  c_cal_to_questionable_group: cover property (
    cal_summary_o && questionable_group_rise[QCS_CAL_SUMMARY_BIT] ##1 questionable_group_event[QCS_CAL_SUMMARY_BIT]);

  c_status_clear: cover property (
    (cal_event != '0) ##1 clear_status_i ##1 cal_event == '0);

  c_event_query: cover property (
    rd_cal_event && cal_event != '0 ##1 rsp_valid_o);

  c_questionable_group_summary: cover property (questionable_group_summary_o);

endmodule
`default_nettype wire

// [bench/qcs_ctl_model.sv]
// Remote controller model issuing status commands
`timescale 1ns/1ps
`default_nettype none
module qcs_ctl_model (
  // Clock
  input wire logic core_clk_i,
  // Command port
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output qcs_pkg::qcs_group_t cmd_group_o,
  output qcs_pkg::qcs_reg_t cmd_reg_o,
  output logic [15:0] cmd_data_o,
  // Answer
  input wire logic rsp_valid_i,
  input wire logic [15:0] rsp_data_i
);
  import qcs_pkg::*;

  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_group_o = QCS_GRP_QUESTIONABLE_GROUP;
    cmd_reg_o = QCS_REG_COND;
    cmd_data_o = 16'h0000;
  end

  // ----------------------------------------------------------------
  // One command, optional idle gap first
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input qcs_group_t g, input qcs_reg_t r,
                      input logic [15:0] d, input int gap,
                      output logic [15:0] q, output logic v);
    repeat (gap) @(posedge core_clk_i);
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_group_o = g;
    cmd_reg_o = r;
    cmd_data_o = d;
    @(posedge core_clk_i);
    #1;
    cmd_valid_o = 1'b0;
    cmd_data_o = ~d;
    q = rsp_data_i;
    v = rsp_valid_i;
  endtask
endmodule
`default_nettype wire

// [bench/questionable_calibration_status_test.sv]
// Self-checking bench for the questionable and calibration status groups
`timescale 1ns/1ps
`default_nettype none
module questionable_calibration_status_test;
  import qcs_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic clear_status_i = 1'b0;
  logic [4:0] cal_fail_i = 5'h00;
  logic cmd_valid_i;
  logic cmd_write_i;
  qcs_group_t cmd_group_i;
  qcs_reg_t cmd_reg_i;
  logic [15:0] cmd_data_i;
  logic rsp_valid_o;
  logic [15:0] rsp_data_o;
  logic questionable_group_summary_o;
  logic cal_summary_o;
  int miscompares = 0;
  int checks = 0;

  always #25 core_clk_i = ~core_clk_i;

  qcs_status_top uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_group_i(cmd_group_i),
    .cmd_reg_i(cmd_reg_i), .cmd_data_i(cmd_data_i), .clear_status_i(clear_status_i),
    .cal_fail_i(cal_fail_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .questionable_group_summary_o(questionable_group_summary_o), .cal_summary_o(cal_summary_o));

  qcs_ctl_model ctl (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_group_o(cmd_group_i), .cmd_reg_o(cmd_reg_i),
    .cmd_data_o(cmd_data_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("Mismatches %0d, checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input qcs_group_t g, input qcs_reg_t r, input logic [15:0] exp);
    logic [15:0] q;
    logic v;
    ctl.xfer(1'b0, g, r, 16'h0000, 0, q, v);
    check1(v, 1'b1);
    check16(q, exp);
  endtask

  task automatic wr(input qcs_group_t g, input qcs_reg_t r, input logic [15:0] d);
    logic [15:0] q;
    logic v;
    ctl.xfer(1'b1, g, r, d, 2, q, v);
    check1(v, 1'b0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    qcs_group_t g;
    for (int i = 0; i < 2; i++) begin
      g = qcs_group_t'(i[0]);
      rd(g, QCS_REG_COND, 16'h0000);
      rd(g, QCS_REG_RISE, 16'h7fff);
      rd(g, QCS_REG_FALL, 16'h0000);
      rd(g, QCS_REG_EVENT, 16'h0000);
      rd(g, QCS_REG_ENABLE, 16'h0000);
      rd(g, qcs_reg_t'(3'h5), 16'h0000);
    end
  endtask

  task automatic t_filters;
    qcs_group_t g;
    for (int i = 0; i < 2; i++) begin
      g = qcs_group_t'(i[0]);
      wr(g, QCS_REG_RISE, 16'h8a5c ^ 16'(i));
      rd(g, QCS_REG_RISE, 16'h8a5c ^ 16'(i));
      wr(g, QCS_REG_FALL, 16'hffff);
      rd(g, QCS_REG_FALL, 16'hffff);
      wr(g, QCS_REG_ENABLE, 16'h5a3c);
      rd(g, QCS_REG_ENABLE, 16'h5a3c);
      rd(g, QCS_REG_ENABLE, 16'h5a3c);
      wr(g, QCS_REG_COND, 16'hffff);
      rd(g, QCS_REG_COND, 16'h0000);
      wr(g, QCS_REG_RISE, 16'h7fff);
      wr(g, QCS_REG_FALL, 16'h0000);
      wr(g, QCS_REG_ENABLE, 16'h0000);
      rd(g, QCS_REG_ENABLE, 16'h0000);
    end
  endtask

  task automatic t_cond;
    for (int b = 0; b < 5; b++) begin
      cal_fail_i = 5'h01 << b;
      cyc(2);
      rd(QCS_GRP_CAL, QCS_REG_COND, 16'h0001 << b);
      rd(QCS_GRP_QUESTIONABLE_GROUP, QCS_REG_COND, 16'h0000);
    end
    cal_fail_i = 5'h00;
    rd(QCS_GRP_CAL, QCS_REG_EVENT, 16'h001f);
    rd(QCS_GRP_CAL, QCS_REG_EVENT, 16'h0000);
  endtask

  task automatic t_fall;
    wr(QCS_GRP_CAL, QCS_REG_RISE, 16'h0000);
    wr(QCS_GRP_CAL, QCS_REG_FALL, 16'h0002);
    cal_fail_i = 5'h02;
    cyc(2);
    rd(QCS_GRP_CAL, QCS_REG_EVENT, 16'h0000);
    cal_fail_i = 5'h00;
    cyc(2);
    rd(QCS_GRP_CAL, QCS_REG_EVENT, 16'h0002);
    wr(QCS_GRP_CAL, QCS_REG_RISE, 16'h7fff);
    wr(QCS_GRP_CAL, QCS_REG_FALL, 16'h0000);
  endtask

  task automatic t_summary;
    wr(QCS_GRP_CAL, QCS_REG_ENABLE, 16'h0004);
    wr(QCS_GRP_QUESTIONABLE_GROUP, QCS_REG_ENABLE, 16'h0100);
    cal_fail_i = 5'h04;
    cyc(2);
    check1(cal_summary_o, 1'b1);
    check1(questionable_group_summary_o, 1'b1);
    rd(QCS_GRP_QUESTIONABLE_GROUP, QCS_REG_COND, 16'h0100);
    rd(QCS_GRP_CAL, QCS_REG_ENABLE, 16'h0004);
    check1(cal_summary_o, 1'b1);
    clear_status_i = 1'b1;
    cyc(1);
    clear_status_i = 1'b0;
    check1(cal_summary_o, 1'b0);
    check1(questionable_group_summary_o, 1'b0);
    rd(QCS_GRP_QUESTIONABLE_GROUP, QCS_REG_COND, 16'h0000);
    cal_fail_i = 5'h00;
    cyc(2);
    cal_fail_i = 5'h04;
    cyc(2);
    check1(cal_summary_o, 1'b1);
    wr(QCS_GRP_CAL, QCS_REG_ENABLE, 16'h0000);
    check1(cal_summary_o, 1'b0);
    rd(QCS_GRP_CAL, QCS_REG_EVENT, 16'h0004);
  endtask

  initial begin
    repeat (20) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_filters();
    t_cond();
    t_fall();
    t_summary();
    complete_run();
  end

  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
